// >>> rtl/smpc_core.sv
`timescale 1ns/100ps
`default_nettype none
module smpc_core #(
  parameter int TB_W = smpc_pkg::TB_WIDTH,
  parameter int OUTS = smpc_pkg::OUT_COUNT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic count_en,
  input wire logic ctrl_in_pin,
  input wire logic comparator1_synced_out,
  input wire logic comparator2_synced_out,
  input wire logic comparator3_synced_out,
  input wire logic comparator4_synced_out,
  input wire logic [TB_W-1:0] period_value,
  input wire logic [TB_W-1:0] phase_value,
  input wire logic [TB_W-1:0] duty_value,
  input wire logic [smpc_pkg::SRC_WIDTH-1:0] period_source_select,
  input wire logic [smpc_pkg::SRC_WIDTH-1:0] phase_source_select,
  input wire logic [smpc_pkg::SRC_WIDTH-1:0] duty_source_select,
  input wire logic [2:0] mode_select,
  input wire logic steer_sync_en,
  input wire logic [OUTS-1:0] steer_enable,
  input wire logic load_set,
  output logic update_load_bit,
  output logic [TB_W-1:0] pulse_timebase_counter,
  output logic period_event,
  output logic rise_event,
  output logic fall_event,
  output logic fall_blank_start,
  output logic rise_blank_start,
  output logic deadband_start,
  output logic [OUTS-1:0] steer_active,
  output logic [OUTS-1:0] pwm_out
);
  initial begin
    if (TB_W < 2 || TB_W > 16 || OUTS < 2 || OUTS > 6) begin
      $error("smpc_core: unsupported width or output count");
    end
  end

  function automatic logic src_or(input logic [smpc_pkg::SRC_WIDTH-1:0] sel, input logic tmr_match,
      input logic [smpc_pkg::SRC_WIDTH-1:0] async_src);
    logic [smpc_pkg::SRC_WIDTH-1:0] srcs;
    srcs = async_src;
    srcs[smpc_pkg::SRC_TMR] = tmr_match;
    src_or = |(sel & srcs);
  endfunction

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [4:0] async_meta_reg;
  logic [4:0] async_sync_reg;
  wire logic [smpc_pkg::SRC_WIDTH-1:0] async_src;
  always_ff @(posedge clock) begin
    if (rst) begin
      async_meta_reg <= 5'h00;
      async_sync_reg <= 5'h00;
    end else begin
      async_meta_reg <= {comparator4_synced_out, comparator3_synced_out, comparator2_synced_out,
        comparator1_synced_out, ctrl_in_pin};
      async_sync_reg <= async_meta_reg;
    end
  end
  assign async_src = {async_sync_reg, 1'b0};

  // ****************************************************
  // time base
  // ****************************************************
  logic [TB_W-1:0] tb_reg;
  logic [TB_W-1:0] tb_next;
  logic period_pend_reg;
  logic period_pend_next;
  wire logic period_match;
  wire logic phase_match;
  wire logic duty_match;
  wire logic period_hit;

  assign period_match = count_en && (tb_reg == period_value);
  assign phase_match = count_en && (tb_reg == phase_value);
  assign duty_match = count_en && (tb_reg == duty_value);
  assign period_hit = src_or(period_source_select, period_match, async_src);
  // an event between counting edges is held until the next counting edge resets the count
  assign period_pend_next = count_en ? 1'b0 : (period_pend_reg | period_hit);
  always_comb begin
    tb_next = tb_reg;
    if (count_en) begin
      if (period_hit || period_pend_reg) begin
        tb_next = smpc_pkg::TB_RESET;
      end else begin
        tb_next = tb_reg + smpc_pkg::TB_STEP[TB_W-1:0];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      tb_reg <= smpc_pkg::TB_RESET[TB_W-1:0];
      period_pend_reg <= 1'b0;
    end else begin
      tb_reg <= tb_next;
      period_pend_reg <= period_pend_next;
    end
  end

  // ****************************************************
  // rising and falling events
  // ****************************************************
  smpc_evt_if evt ();
  assign evt.period_hit = period_hit;
  assign evt.rise_hit = src_or(phase_source_select, phase_match, async_src);
  assign evt.fall_hit = src_or(duty_source_select, duty_match, async_src);

  smpc_event_gate u_gate (
    .clock(clock),
    .rst(rst),
    .evt(evt)
  );

  // ****************************************************
  // steering
  // ****************************************************
  logic [OUTS-1:0] steer_reg;
  logic [OUTS-1:0] steer_next;
  logic load_reg;
  logic load_next;
  wire logic steer_mode_ok;
  wire logic [OUTS-1:0] steer_req;
  wire logic transfer;

  // steering outside its modes is frozen at the first output
  assign steer_mode_ok = (mode_select == smpc_pkg::SMPC_MODE_SINGLE) ||
    (mode_select == smpc_pkg::SMPC_MODE_COMPL) || (mode_select == smpc_pkg::SMPC_MODE_THREE_PHASE);
  assign steer_req = steer_mode_ok ? steer_enable : smpc_pkg::STEER_RESET[OUTS-1:0];
  assign transfer = load_reg && period_hit;
  assign steer_next = !steer_sync_en ? steer_req : (transfer ? steer_req : steer_reg);
  // set wins over the clearing transfer
  assign load_next = load_set ? 1'b1 : (transfer ? 1'b0 : load_reg);
  always_ff @(posedge clock) begin
    if (rst) begin
      steer_reg <= smpc_pkg::STEER_RESET[OUTS-1:0];
      load_reg <= 1'b0;
    end else begin
      steer_reg <= steer_next;
      load_reg <= load_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  typedef smpc_pkg::smpc_mode_t smpc_mode_t;
  logic [OUTS-1:0] pwm_reg;
  logic [OUTS-1:0] pwm_next;
  logic [5:0] strobe_reg;
  wire logic drive;
  // drive level after this cycle's accepted events; fall wins so full duty still ends
  assign drive = evt.fall_take ? 1'b0 : (evt.rise_take ? 1'b1 : evt.rise_active);
  always_comb begin
    pwm_next = '0;
    case (smpc_mode_t'(mode_select))
      smpc_pkg::SMPC_MODE_SINGLE: pwm_next = drive ? steer_reg : '0;
      smpc_pkg::SMPC_MODE_COMPL: begin
        pwm_next = steer_reg & {OUTS{drive}};
        pwm_next[1] = steer_reg[1] & !drive;
      end
      smpc_pkg::SMPC_MODE_THREE_PHASE: pwm_next = drive ? steer_reg : '0;
      default: pwm_next[0] = drive;
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_reg <= '0;
      strobe_reg <= 6'h00;
    end else begin
      pwm_reg <= pwm_next;
      strobe_reg <= {period_hit, evt.rise_take, evt.fall_take, evt.rise_take, evt.fall_take,
        evt.rise_take | evt.fall_take};
    end
  end

  assign pwm_out = pwm_reg;
  assign steer_active = steer_reg;
  assign update_load_bit = load_reg;
  assign pulse_timebase_counter = tb_reg;
  assign period_event = strobe_reg[5];
  assign rise_event = strobe_reg[4];
  assign fall_event = strobe_reg[3];
  assign fall_blank_start = strobe_reg[2];
  assign rise_blank_start = strobe_reg[1];
  assign deadband_start = strobe_reg[0];
endmodule
`default_nettype wire

// >>> common/smpc_pkg.sv
package smpc_pkg;
  localparam int TB_WIDTH = 16;
  localparam int SRC_WIDTH = 6;
  localparam int OUT_COUNT = 6;
  // source select bit positions
  localparam int SRC_TMR = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_CMP1 = 2;
  localparam logic [TB_WIDTH-1:0] TB_RESET = 16'h0000;
  localparam logic [TB_WIDTH-1:0] TB_STEP = 16'h0001;
  localparam logic [OUT_COUNT-1:0] STEER_RESET = 6'h01;

  typedef enum logic [2:0] {
    SMPC_MODE_SINGLE = 3'b000,
    SMPC_MODE_COMPL = 3'b001,
    SMPC_MODE_THREE_PHASE = 3'b010,
    SMPC_MODE_PUSH_PULL = 3'b011,
    SMPC_MODE_OTHER = 3'b111
  } smpc_mode_t;
endpackage

// >>> common/smpc_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
// event selection inputs and accepted event strobes between top and gate
interface smpc_evt_if;
  logic period_hit;
  logic rise_hit;
  logic fall_hit;
  logic rise_take;
  logic fall_take;
  logic rise_active;
  modport ctrl (output period_hit, output rise_hit, output fall_hit, input rise_take, input fall_take,
    input rise_active);
  modport gate (input period_hit, input rise_hit, input fall_hit, output rise_take, output fall_take,
    output rise_active);
endinterface
`default_nettype wire

// >>> rtl/smpc_event_gate.sv
`timescale 1ns/100ps
`default_nettype none
module smpc_event_gate (
  input wire logic clock,
  input wire logic rst,
  smpc_evt_if.gate evt
);
  logic rise_done_reg;
  logic rise_done_next;
  logic fall_done_reg;
  logic fall_done_next;
  wire logic rise_ok;
  wire logic fall_ok;

  // ****************************************************
  // once-per-period suppression
  // ****************************************************
  // an event in the period cycle belongs to the new period, so the old flags do not gate it
  assign rise_ok = evt.rise_hit && (evt.period_hit || (!rise_done_reg && !fall_done_reg));
  assign fall_ok = evt.fall_hit && (evt.period_hit || !fall_done_reg);
  assign evt.rise_take = rise_ok;
  assign evt.fall_take = fall_ok;
  assign evt.rise_active = rise_done_reg && !fall_done_reg;
  // a period event reopens both windows; a same-cycle event then counts for the new period
  assign rise_done_next = evt.period_hit ? rise_ok : (rise_done_reg | rise_ok);
  assign fall_done_next = evt.period_hit ? fall_ok : (fall_done_reg | fall_ok);

  always_ff @(posedge clock) begin
    if (rst) begin
      rise_done_reg <= 1'b0;
      fall_done_reg <= 1'b0;
    end else begin
      rise_done_reg <= rise_done_next;
      fall_done_reg <= fall_done_next;
    end
  end
endmodule
`default_nettype wire

// >>> tb/smpc_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module smpc_chk #(parameter int TB_W = 16, parameter int OUTS = 6) (
  input wire logic clock,
  input wire logic rst,
  input wire logic count_en,
  input wire logic [TB_W-1:0] period_value,
  input wire logic [5:0] period_source_select,
  input wire logic steer_sync_en,
  input wire logic load_set,
  input wire logic update_load_bit,
  input wire logic [TB_W-1:0] pulse_timebase_counter,
  input wire logic period_event,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic fall_blank_start,
  input wire logic rise_blank_start,
  input wire logic deadband_start,
  input wire logic [OUTS-1:0] steer_active
);
  // ****************
  // period memory and properties
  // ****************
  logic rise_seen_reg, fall_seen_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a strobe sharing a cycle with the period strobe belongs to the new period
  always_ff @(posedge clock) begin
    if (rst) begin
      rise_seen_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else begin
      rise_seen_reg <= rise_event | (rise_seen_reg & ~period_event);
      fall_seen_reg <= fall_event | (fall_seen_reg & ~period_event);
    end
  end
  period_hit_a: assert property (count_en && period_source_select[0] && pulse_timebase_counter == period_value
    |=> period_event) else $error("period strobe missing");
  count_restart_a: assert property (count_en && period_source_select == 6'h01 && period_value != 16'h0000 &&
    pulse_timebase_counter == period_value ##1 count_en |=> pulse_timebase_counter == 16'h0001)
    else $error("counter did not restart");
  rise_once_a: assert property (rise_event && !period_event |-> !rise_seen_reg) else $error("second rise");
  fall_once_a: assert property (fall_event && !period_event |-> !fall_seen_reg) else $error("second fall");
  rise_block_a: assert property (rise_event && !period_event |-> !fall_seen_reg) else $error("rise after fall");
  blank_timers_a: assert property (fall_blank_start == rise_event && rise_blank_start == fall_event &&
    deadband_start == (rise_event || fall_event)) else $error("timer start mismatch");
  load_clear_a: assert property (update_load_bit && !load_set ##1 period_event
    |-> !update_load_bit) else $error("load bit kept");
  steer_hold_a: assert property (steer_sync_en && !update_load_bit && !load_set |=> $stable(steer_active))
    else $error("steering moved early");
  cover property (rise_event ##[1:40] fall_event);
  cover property (fall_event && !rise_seen_reg);
  cover property (period_event && update_load_bit);
endmodule
bind smpc_core smpc_chk #(.TB_W(TB_W), .OUTS(OUTS)) u_chk (.clock, .rst, .count_en, .period_value,
  .period_source_select, .steer_sync_en, .load_set, .update_load_bit, .pulse_timebase_counter, .period_event,
  .rise_event, .fall_event, .fall_blank_start, .rise_blank_start, .deadband_start, .steer_active);
`default_nettype wire

// >>> tb/smpc_power_stage.sv
`timescale 1ns/100ps
`default_nettype none
// load model: the stage conducts while any gate drive is high
module smpc_power_stage (
  input wire logic clock,
  input wire logic [5:0] gate,
  output logic load_on
);
  always_ff @(posedge clock) begin
    load_on <= |gate;
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ****************
  // stimulus, notes and watcher
  // ****************
  logic clock = 1'b0, rst = 1'b1, count_en = 1'b0, steer_sync_en = 1'b0, load_set = 1'b0;
  logic [4:0] async_in = 5'h00, a;
  logic [15:0] period_value = 16'h0000, phase_value = 16'h0000, duty_value = 16'h0000, pulse_timebase_counter;
  logic [5:0] period_source_select = 6'h00, phase_source_select = 6'h00, duty_source_select = 6'h00;
  logic [5:0] steer_enable = 6'h00, steer_active, pwm_out, cur, nxt;
  logic [2:0] mode_select = 3'h0;
  logic update_load_bit, period_event, rise_event, fall_event, fall_blank_start, rise_blank_start, deadband_start;
  logic [7:0] notes[$];
  int fails = 0, n_compared = 0, cycles = 0, kind, ph, dt, m;
  bit s;
  initial forever #12.5 clock = ~clock;
  smpc_core dut (.clock, .rst, .count_en, .ctrl_in_pin(async_in[0]), .comparator1_synced_out(async_in[1]),
    .comparator2_synced_out(async_in[2]), .comparator3_synced_out(async_in[3]), .comparator4_synced_out(async_in[4]),
    .period_value, .phase_value, .duty_value, .period_source_select, .phase_source_select, .duty_source_select,
    .mode_select, .steer_sync_en, .steer_enable, .load_set, .update_load_bit, .pulse_timebase_counter,
    .period_event, .rise_event, .fall_event, .fall_blank_start, .rise_blank_start, .deadband_start,
    .steer_active, .pwm_out);
  smpc_power_stage stage (.clock, .gate(pwm_out), .load_on());
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch events_pwm expected %h seen %h", exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_cnt(input int v);
    do @(posedge clock); while (pulse_timebase_counter !== 16'(v));
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end
  always @(posedge clock) begin
    if (!rst && (rise_event || fall_event)) begin
      if (notes.size() == 0) check({rise_event, fall_event, pwm_out}, 8'hFF);
      else check({rise_event, fall_event, pwm_out}, notes.pop_front());
    end
  end
  // each period picks timer-only, async-led rise, or early async fall that must swallow the rise
  initial begin
    void'($urandom(7));
    cur = 6'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    count_en <= 1'b1;
    period_source_select <= 6'h01;
    period_value <= 16'h0010;
    do @(posedge clock); while (period_event !== 1'b1);
    repeat (40) begin
      kind = $urandom_range(2);
      ph = $urandom_range(11, 8);
      dt = ph + $urandom_range(8, 3);
      a = 5'h01 << $urandom_range(4);
      nxt = 6'($urandom);
      s = 1'($urandom);
      m = $urandom_range(2);
      mode_select <= 3'(m);
      phase_value <= 16'(ph);
      duty_value <= 16'(dt);
      period_value <= 16'(dt + 6);
      phase_source_select <= (kind == 1) ? {a, 1'b1} : 6'h01;
      duty_source_select <= (kind == 2) ? {a, 1'b1} : 6'h01;
      async_in <= (kind == 0) ? 5'h00 : a;
      steer_enable <= nxt;
      steer_sync_en <= s;
      if (!s) cur = nxt;
      if (kind != 2) notes.push_back({2'h2, (m == 1) ? (cur & 6'h3D) : cur});
      notes.push_back({2'h1, (m == 1) ? (cur & 6'h02) : 6'h00});
      wait_cnt(ph + 1);
      if (kind == 1) async_in <= 5'h00;
      wait_cnt(dt + 1);
      async_in <= 5'h00;
      load_set <= s;
      @(posedge clock);
      load_set <= 1'b0;
      if (s) cur = nxt;
      do @(posedge clock); while (period_event !== 1'b1);
    end
    repeat (10) @(posedge clock);
    check(8'(notes.size()), 8'h00);
    results();
  end
endmodule
`default_nettype wire
